// ==== prs_rail_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing figures
 * for the rail status register bank.
 * Assumes a 50 MHz logic clock and an 8-bit register address space.
 */
`ifndef PRS_RAIL_REGS_SVH
`define PRS_RAIL_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PRS_OFF_AUX_CTRL 8'hAE
`define PRS_OFF_PG_A 8'hB0
`define PRS_OFF_PG_B 8'hB1
`define PRS_OFF_FLT_A 8'hB2

// ----------------------------------------------------------------
// Auxiliary control fields and reset values
// ----------------------------------------------------------------
`define PRS_DIS_MSB 7
`define PRS_DIS_LSB 6
`define PRS_ESD_MODE_BIT 5
`define PRS_VCODE_MSB 4
`define PRS_VCODE_LSB 1
`define PRS_EN_BIT 0
`define PRS_AUX_CTRL_RST 8'h40
`define PRS_STATUS_RST 8'h00
`define PRS_PG_B_WIDTH 6

// ----------------------------------------------------------------
// Emergency off durations
// ----------------------------------------------------------------
`define PRS_CLK_KHZ 50000
`define PRS_OFF_T0_MS 1
`define PRS_OFF_T1_MS 5
`define PRS_OFF_T2_MS 10
`define PRS_OFF_T3_MS 100

`endif

// ==== prs_rail_pkg.sv ====
/*
 * Types shared by the rail status register bank.
 * Assumes the constants of prs_rail_regs.svh for widths and offsets.
 */
package prs_rail_pkg;

    // ------------------------------------------------------------
    // Emergency-off state, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PRS_ST_RUN = 2'b01,
        PRS_ST_OFF = 2'b10
    } prs_esd_st_t;

    // Register access request from the serial front end
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } prs_req_t;

    // Analog comparator levels
    typedef struct packed {
        logic [7:0] pg_a;
        logic [5:0] pg_b;
        logic [7:0] flt_a;
    } prs_ana_t;

    // Rail drive outputs
    typedef struct packed {
        logic ldo_en;
        logic sw_en;
        logic [3:0] dis_onehot;
        logic [3:0] vcode;
    } prs_drive_t;

    // Whole state of the bank
    typedef struct packed {
        prs_esd_st_t st;
        logic [22:0] tmr;
        logic [7:0] ctrl;
        prs_ana_t sync1;
        prs_ana_t sync2;
        logic [7:0] flt;
        logic [7:0] rdata;
        prs_drive_t drv;
    } prs_state_t;

endpackage

// ==== prs_rail_status_regs.sv ====
/*
 * Register bank for the auxiliary rail control, the two power-good
 * status registers and the first power-fault status register.
 * Assumes a serial front end on the same clock that presents one-cycle
 * read and write strobes with an 8-bit offset; comparator inputs are
 * asynchronous; the emergency shutdown request is a same-clock level.
 */
`timescale 1ns/1ps
`include "prs_rail_regs.svh"

module prs_rail_status_regs
    import prs_rail_pkg::*;
#(
    parameter logic [7:0] AUX_CTRL_RST = `PRS_AUX_CTRL_RST,
    parameter bit TARGET_IS_SWITCH = 1'b0,
    parameter logic [1:0] OFF_DUR_SEL = 2'd0,
    parameter int OFF_T0_CYC = `PRS_OFF_T0_MS * `PRS_CLK_KHZ,
    parameter int OFF_T1_CYC = `PRS_OFF_T1_MS * `PRS_CLK_KHZ,
    parameter int OFF_T2_CYC = `PRS_OFF_T2_MS * `PRS_CLK_KHZ,
    parameter int OFF_T3_CYC = `PRS_OFF_T3_MS * `PRS_CLK_KHZ
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire prs_req_t req_i,
    input wire prs_ana_t ana_i,
    input wire logic esd_req_i,
    output logic [7:0] rdata_o,
    output prs_drive_t drive_o
);

    // ----------------------------------------------------------------
    // Duration selection
    // ----------------------------------------------------------------
    // Factory choice is fixed at build time, so it folds to a constant
    localparam int OFF_CYC = (OFF_DUR_SEL == 2'd0) ? OFF_T0_CYC :
                             (OFF_DUR_SEL == 2'd1) ? OFF_T1_CYC :
                             (OFF_DUR_SEL == 2'd2) ? OFF_T2_CYC : OFF_T3_CYC;
    localparam logic [22:0] OFF_LOAD = 23'(OFF_CYC - 1);

    localparam prs_state_t RST_STATE = '{
        st: PRS_ST_RUN,
        tmr: '0,
        ctrl: AUX_CTRL_RST,
        sync1: '0,
        sync2: '0,
        flt: `PRS_STATUS_RST,
        rdata: '0,
        // Discharge select and voltage code match the reset control word, so no invalid code shows; both enables reset to 0
        drv: '{
            ldo_en: 1'b0,
            sw_en: 1'b0,
            dis_onehot: 4'b0001 << AUX_CTRL_RST[`PRS_DIS_MSB:`PRS_DIS_LSB],
            vcode: AUX_CTRL_RST[`PRS_VCODE_MSB:`PRS_VCODE_LSB]
        }
    };

    prs_state_t s_q;
    prs_state_t s_d;
    logic mode_ignore;
    logic rail_on;
    logic [7:0] flt_clr;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Two-stage synchroniser; stage one feeds stage two only
        s_d.sync1 = ana_i;
        s_d.sync2 = s_q.sync1;

        // Control register write
        if (req_i.wr && req_i.addr == `PRS_OFF_AUX_CTRL) begin
            s_d.ctrl = req_i.wdata;
        end

        // Sticky faults: set wins over a same-cycle write-one clear
        flt_clr = '0;
        if (req_i.wr && req_i.addr == `PRS_OFF_FLT_A) begin
            flt_clr = req_i.wdata;
        end
        s_d.flt = (s_q.flt & ~flt_clr) | s_q.sync2.flt_a;

        // Emergency shutdown sequencing
        mode_ignore = s_q.ctrl[`PRS_ESD_MODE_BIT];
        case (s_q.st)
            PRS_ST_RUN: begin
                if (esd_req_i && !mode_ignore) begin
                    s_d.st = PRS_ST_OFF;
                    s_d.tmr = OFF_LOAD;
                end
            end
            PRS_ST_OFF: begin
                // Switching to ignore mode releases the hold at once
                if (mode_ignore || s_q.tmr == '0) begin
                    s_d.st = PRS_ST_RUN;
                    s_d.tmr = '0;
                end else begin
                    s_d.tmr = s_q.tmr - 23'd1;
                end
            end
            default: begin
                s_d.st = PRS_ST_RUN;
                s_d.tmr = '0;
            end
        endcase

        // Rail drive, from the state just computed
        rail_on = s_d.ctrl[`PRS_EN_BIT] && (s_d.st == PRS_ST_RUN);
        s_d.drv.ldo_en = rail_on && !TARGET_IS_SWITCH;
        s_d.drv.sw_en = rail_on && TARGET_IS_SWITCH;
        s_d.drv.vcode = s_d.ctrl[`PRS_VCODE_MSB:`PRS_VCODE_LSB];
        case (s_d.ctrl[`PRS_DIS_MSB:`PRS_DIS_LSB])
            2'b00: s_d.drv.dis_onehot = 4'b0001;
            2'b01: s_d.drv.dis_onehot = 4'b0010;
            2'b10: s_d.drv.dis_onehot = 4'b0100;
            default: s_d.drv.dis_onehot = 4'b1000;
        endcase

        // Read data, registered; unmapped offsets answer zero
        if (req_i.rd) begin
            if (req_i.addr == `PRS_OFF_AUX_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else if (req_i.addr == `PRS_OFF_PG_A) begin
                s_d.rdata = s_q.sync2.pg_a;
            end else if (req_i.addr == `PRS_OFF_PG_B) begin
                s_d.rdata = {2'b00, s_q.sync2.pg_b};
            end else if (req_i.addr == `PRS_OFF_FLT_A) begin
                s_d.rdata = s_q.flt;
            end else begin
                s_d.rdata = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign drive_o = s_q.drv;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    AST_DISCH_DECODE: assert property (
        s_q.drv.dis_onehot == (4'b0001 << s_q.ctrl[7:6]))
        else $error("discharge select does not match control code");

    AST_ESD_OFF: assert property (
        (s_q.st == PRS_ST_RUN && esd_req_i && !s_q.ctrl[5])
        |=> (s_q.st == PRS_ST_OFF && !drive_o.ldo_en && !drive_o.sw_en) [*3])
        else $error("rail not held off after emergency shutdown");

    AST_ESD_IGNORED: assert property (
        (s_q.st == PRS_ST_RUN && s_q.ctrl[5]) |=> s_q.st == PRS_ST_RUN)
        else $error("emergency shutdown acted in ignore mode");

    AST_TARGET: assert property (
        TARGET_IS_SWITCH ? !drive_o.ldo_en : !drive_o.sw_en)
        else $error("wrong rail target driven");

    AST_VCODE: assert property (
        (req_i.wr && req_i.addr == 8'hAE) |=> drive_o.vcode == $past(req_i.wdata[4:1]))
        else $error("voltage code not applied");

    AST_ENABLE: assert property (
        (req_i.wr && req_i.addr == 8'hAE && s_q.st == PRS_ST_RUN && !esd_req_i)
        |=> (drive_o.ldo_en | drive_o.sw_en) == $past(req_i.wdata[0]))
        else $error("enable bit not applied to rail");

    AST_PG_A_READ: assert property (
        (req_i.rd && req_i.addr == 8'hB0) |=> rdata_o == $past(s_q.sync2.pg_a))
        else $error("power-good A read mismatch");

    AST_PG_FOLLOW: assert property (
        $stable(ana_i.pg_a) [*3] |-> s_q.sync2.pg_a == ana_i.pg_a)
        else $error("power-good bit does not follow comparator");

    AST_PG_B_RSVD: assert property (
        (req_i.rd && req_i.addr == 8'hB1) |=> rdata_o[7:6] == 2'b00)
        else $error("reserved power-good bits not zero");

    AST_FLT_READ: assert property (
        (req_i.rd && req_i.addr == 8'hB2) |=> rdata_o == $past(s_q.flt))
        else $error("fault register read mismatch");

    AST_FLT_STICKY: assert property (
        (s_q.flt[0] && !(req_i.wr && req_i.addr == 8'hB2 && req_i.wdata[0]))
        |=> s_q.flt[0])
        else $error("fault flag lost without a clear");

    AST_FLT_SET_WINS: assert property (
        s_q.sync2.flt_a[0] |=> s_q.flt[0])
        else $error("fault event lost against clear");

    AST_FLT_CLEAR: assert property (
        (s_q.flt[0] && req_i.wr && req_i.addr == 8'hB2 && req_i.wdata[0]
            && !s_q.sync2.flt_a[0]) |=> !s_q.flt[0])
        else $error("fault flag not cleared by a written one");

    AST_FLT_KEEP_ZERO: assert property (
        (s_q.flt[7] && req_i.wr && req_i.addr == 8'hB2 && !req_i.wdata[7]) |=> s_q.flt[7])
        else $error("fault flag lost on a written zero");

    // ----------------------------------------------------------------
    // Checks: status, read path and control writes
    // ----------------------------------------------------------------
    AST_PG_B_READ: assert property (
        (req_i.rd && req_i.addr == 8'hB1) |=> rdata_o == {2'b00, $past(s_q.sync2.pg_b)})
        else $error("power-good B read mismatch");

    AST_PG_B_FOLLOW: assert property (
        $stable(ana_i.pg_b) [*3] |-> s_q.sync2.pg_b == ana_i.pg_b)
        else $error("power-good B bit does not follow comparator");

    AST_UNMAPPED_READ: assert property (
        (req_i.rd && req_i.addr != 8'hAE && req_i.addr != 8'hB0 && req_i.addr != 8'hB1
            && req_i.addr != 8'hB2) |=> rdata_o == 8'h00)
        else $error("unmapped offset did not read zero");

    // Host may poll slowly, so read data must stand between strobes
    AST_RDATA_HOLD: assert property (
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read strobe");

    AST_CTRL_WRITE: assert property (
        (req_i.wr && req_i.addr == 8'hAE) |=> s_q.ctrl == $past(req_i.wdata))
        else $error("control register did not take the written byte");

    AST_VCODE_HOLD: assert property (
        !(req_i.wr && req_i.addr == 8'hAE) |=> $stable(drive_o.vcode))
        else $error("voltage code changed without a control write");

    // ----------------------------------------------------------------
    // Checks: emergency hold timing
    // ----------------------------------------------------------------
    // The counter starts at the full factory duration less the load edge
    AST_HOLD_LOAD: assert property (
        (s_q.st == PRS_ST_RUN && esd_req_i && !s_q.ctrl[5])
        |=> s_q.tmr == 23'(OFF_CYC - 1))
        else $error("hold counter not loaded with the duration");

    AST_HOLD_STAY: assert property (
        (s_q.st == PRS_ST_OFF && s_q.tmr != '0 && !s_q.ctrl[5])
        |=> s_q.st == PRS_ST_OFF)
        else $error("rail released before the hold ran out");

    AST_HOLD_RELEASE: assert property (
        (s_q.st == PRS_ST_OFF && s_q.tmr == '0) |=> s_q.st == PRS_ST_RUN)
        else $error("rail not released at the end of the hold");

    // Ignore mode must not leave a rail stuck off from an earlier request
    AST_HOLD_ABORT: assert property (
        (s_q.st == PRS_ST_OFF && s_q.ctrl[5]) |=> s_q.st == PRS_ST_RUN)
        else $error("hold kept after switching to ignore mode");

    AST_RAIL_OFF_IN_HOLD: assert property (
        s_q.st == PRS_ST_OFF |-> !drive_o.ldo_en && !drive_o.sw_en)
        else $error("rail enabled during an emergency hold");

    AST_ST_ONEHOT: assert property (
        $onehot(s_q.st))
        else $error("emergency state not one-hot");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    COV_ESD_CYCLE: cover property (
        s_q.st == PRS_ST_OFF ##1 s_q.st == PRS_ST_RUN);
    COV_FLT_CLEAR: cover property (
        s_q.flt[3] ##1 !s_q.flt[3]);
    COV_PG_READ: cover property (
        req_i.rd && req_i.addr == 8'hB1 ##1 rdata_o != 8'h00);
    COV_HOLD_ABORT: cover property (
        s_q.st == PRS_ST_OFF && s_q.ctrl[5] ##1 s_q.st == PRS_ST_RUN);
    COV_FLT_KEEP: cover property (
        s_q.flt[7] && req_i.wr && req_i.addr == 8'hB2 && !req_i.wdata[7] ##1 s_q.flt[7]);

endmodule

// ==== prs_host_model.sv ====
/*
 * Host model for the rail status register bank: single-byte register
 * reads and writes on the bank's strobe interface.
 * Assumes the bank samples strobes at the rising clock edge and answers
 * a read one edge later.
 */
`timescale 1ns/1ps

module prs_host_model
    import prs_rail_pkg::*;
(
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output prs_req_t req_o
);
    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // Idle bus from time zero, so no strobe is seen before reset ends
    initial begin
        req_o = '0;
    end

    // One-cycle write strobe; offset and data held with it
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        req_o <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge clock_i);
        req_o.wr <= 1'b0;
    endtask

    // One-cycle read strobe; data taken once the sampling edge settles
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock_i);
        req_o <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clock_i);
        req_o.rd <= 1'b0;
        #1;
        data = rdata_i;
    endtask
endmodule

// ==== testbench.sv ====
/*
 * Self-checking testbench for the rail status register bank.
 * Assumes the host model for bus cycles and a shortened off hold.
 */
`timescale 1ns/1ps
`include "prs_rail_regs.svh"

module testbench
    import prs_rail_pkg::*;
;
    // --------------------------------------------------------------
    // Design and host
    // --------------------------------------------------------------
    localparam int OFF_CYC = 8;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    prs_req_t req;
    prs_ana_t ana = '0;
    logic esd = 1'b0;
    logic [7:0] rdata;
    prs_drive_t drv;
    prs_drive_t drv_sw;
    int n_fail = 0;
    int tests_run = 0;
    int k;

    prs_rail_status_regs #(.OFF_T0_CYC(OFF_CYC)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .req_i(req), .ana_i(ana), .esd_req_i(esd), .rdata_o(rdata), .drive_o(drv));
    // Same stimulus with the switch target, so both enable routes are seen
    prs_rail_status_regs #(.OFF_T0_CYC(OFF_CYC), .TARGET_IS_SWITCH(1'b1)) i_dut_sw (
        .clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .ana_i(ana), .esd_req_i(esd),
        .rdata_o(), .drive_o(drv_sw));
    prs_host_model i_host (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));

    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // --------------------------------------------------------------
    // Checks and verdict
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(addr, d);
        chk(name, exp, d);
    endtask

    // Both targets: only the selected rail's enable may follow the bit
    task automatic dchk(input logic [3:0] dis, input logic [3:0] vc, input logic en);
        chk("drive", {dis, vc}, {drv.dis_onehot, drv.vcode});
        chk("enables", {6'h0, 1'b0, en}, {6'h0, drv.sw_en, drv.ldo_en});
        chk("sw_enables", {6'h0, en, 1'b0}, {6'h0, drv_sw.sw_en, drv_sw.ldo_en});
    endtask

    // Hang guard, far beyond the 75 or so cycles the sequence takes
    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        #1;
        dchk(4'b0010, 4'h0, 1'b0);
        rdchk("aux_ctrl", `PRS_OFF_AUX_CTRL, `PRS_AUX_CTRL_RST);
        rdchk("pg_a", `PRS_OFF_PG_A, 8'h00);
        rdchk("pg_b", `PRS_OFF_PG_B, 8'h00);
        rdchk("flt_a", `PRS_OFF_FLT_A, 8'h00);
        rdchk("unmapped", 8'h55, 8'h00);
        // Every discharge code, voltage code 5, rail enabled
        for (int c = 0; c < 4; c++) begin
            i_host.wr(`PRS_OFF_AUX_CTRL, {c[1:0], 6'b001011});
            @(posedge clock_i);
            #1;
            dchk(4'b0001 << c, 4'h5, 1'b1);
        end
        // Status levels; fault pulse long enough to cross both stages
        @(posedge clock_i);
        ana <= '{pg_a: 8'hA5, pg_b: 6'h2B, flt_a: 8'h81};
        repeat (4) @(posedge clock_i);
        ana.flt_a <= 8'h00;
        rdchk("pg_a", `PRS_OFF_PG_A, 8'hA5);
        i_host.wr(`PRS_OFF_PG_B, 8'hFF);
        rdchk("pg_b", `PRS_OFF_PG_B, 8'h2B);
        rdchk("flt_a", `PRS_OFF_FLT_A, 8'h81);
        i_host.wr(`PRS_OFF_FLT_A, 8'h00);
        rdchk("flt_a", `PRS_OFF_FLT_A, 8'h81);
        i_host.wr(`PRS_OFF_FLT_A, 8'h01);
        rdchk("flt_a", `PRS_OFF_FLT_A, 8'h80);
        // Emergency off in mode 0, then the rail returns after the hold
        @(posedge clock_i);
        esd <= 1'b1;
        @(posedge clock_i);
        esd <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("esd_off", 8'h00, {7'h0, drv.ldo_en});
        chk("esd_off_sw", 8'h00, {7'h0, drv_sw.sw_en});
        k = 1;
        while (drv.ldo_en !== 1'b1 && k < 40) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        // Rail returns OFF_CYC edges after the edge that took the request
        chk("off_cycles", 8'(OFF_CYC), k[7:0]);
        // Ignore mode written during a hold ends it well before it runs out
        @(posedge clock_i);
        esd <= 1'b1;
        @(posedge clock_i);
        esd <= 1'b0;
        i_host.wr(`PRS_OFF_AUX_CTRL, 8'h2B);
        @(posedge clock_i);
        #1;
        chk("esd_abort", 8'h01, {7'h0, drv.ldo_en});
        chk("esd_abort_sw", 8'h01, {7'h0, drv_sw.sw_en});
        // Mode 1: requests are ignored, rail follows the enable bit
        i_host.wr(`PRS_OFF_AUX_CTRL, 8'h2B);
        @(posedge clock_i);
        esd <= 1'b1;
        repeat (3) @(posedge clock_i);
        esd <= 1'b0;
        #1;
        chk("esd_ignored", 8'h01, {7'h0, drv.ldo_en});
        conclude();
    end
endmodule
